// *** common/sov_defines.svh ***
// register map, reset values and timing constants of the offset-stop block
`ifndef SOV_DEFINES_SVH
`define SOV_DEFINES_SVH
`define SOV_ADDR_CTRL 8'h00
`define SOV_ADDR_RUN_VEL 8'h04
`define SOV_ADDR_OFS_VEL 8'h08
`define SOV_ADDR_OFS_DIST 8'h0C
`define SOV_ADDR_ACT_SEL 8'h10
`define SOV_ADDR_VEL_LIM 8'h14
`define SOV_ADDR_POS_LIM 8'h18
`define SOV_ADDR_DECEL 8'h1C
`define SOV_ADDR_STATUS 8'h20
`define SOV_ADDR_POSITION 8'h24
`define SOV_ADDR_LATCH 8'h28
`define SOV_CTRL_START_POS 0
`define SOV_CTRL_START_NEG 1
`define SOV_CTRL_STOP 2
`define SOV_CTRL_SAVE 3
`define SOV_OFS_VEL_MIN 24'h00_0001
`define SOV_OFS_VEL_DEF 24'h00_03E8
`define SOV_OFS_DIST_DEF 24'h00_0000
`define SOV_ACT_DEF 2'h2
`define SOV_ACT_HARD 2'h0
`define SOV_ACT_SOFT 2'h1
`define SOV_ACT_OFFSET 2'h2
`define SOV_RUN_VEL_DEF 24'h00_2710
`define SOV_VEL_LIM_DEF 24'h0F_4240
`define SOV_POS_LIM_DEF 24'hFF_FFFF
`define SOV_DECEL_DEF 24'h00_0064
`define SOV_MILLI_TO_MICRO 34'h0_0000_03E8
`define SOV_CLK_NS 10
`define SOV_TICK_NS 1000000
`define SOV_RESP_OKAY 2'h0
`define SOV_RESP_SLVERR 2'h2
`endif

// *** common/sov_pkg.sv ***
// shared types of the offset-stop motion block
package sov_pkg;
  // motion states, one-hot
  typedef enum logic [3:0] {
    SOV_IDLE = 4'h1,
    SOV_RUN = 4'h2,
    SOV_OFFS = 4'h4,
    SOV_SOFT = 4'h8
  } sov_state_t;
  // command toward the motor driver
  typedef struct packed {
    logic moving;
    logic dir_neg;
    logic [23:0] speed;
  } sov_motor_t;
endpackage : sov_pkg

// *** design/sov_sync3.sv ***
// three-stage synchroniser with agreement filter for a pin input
module sov_sync3 (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic d,
  output logic q
);
  logic ff1_r;
  logic ff2_r;
  logic ff3_r;
  // shift chain; ff1 feeds ff2 only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ff1_r <= 1'b0;
      ff2_r <= 1'b0;
      ff3_r <= 1'b0;
    end else begin
      ff1_r <= d;
      ff2_r <= ff1_r;
      ff3_r <= ff2_r;
    end
  end
  // accept a change once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= 1'b0;
    end else if (ff2_r == ff3_r) begin
      q <= ff3_r;
    end
  end
endmodule : sov_sync3

// *** design/sov_offset_stop.sv ***
// continuous move controller with sensor offset stop and axi4-lite regs
// Operation
// - offset velocity accepted from 0.001 to limit
// - new offset velocity applies at once
// - saved value restored at power up
// - unsaved offset velocity defaults to 1.0
// - sensor in continuous move selects offset velocity
// - stop after offset distance travelled
// - offset stop in both directions
// - offset velocity reachable over command paths
// - offset distance accepted from 0 to limit
// - action 0 hard stop, 1 soft stop
// - distance measured from latched sensor position
`include "sov_defines.svh"
module sov_offset_stop #(
  parameter int TICK_CYCLES = `SOV_TICK_NS / `SOV_CLK_NS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic nv_init_n,
  input wire logic sensor_in,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output sov_pkg::sov_motor_t motor_cmd
);
  sov_pkg::sov_state_t st_r;
  logic [23:0] ofs_vel_r, ofs_dist_r, run_vel_r, vel_lim_r, pos_lim_r;
  logic [23:0] decel_r, speed_r, nv_vel_r, nv_dist_r;
  logic [1:0] act_r, nv_act_r;
  logic nv_saved_r, dir_r, moving_r, sensed_r, sens_d_r, sens_q;
  logic start_pos_r, start_neg_r, stop_r, save_r;
  logic aw_got_r, w_got_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r, rd_val;
  logic [31:0] pos_r, latch_r, pos_nxt;
  logic [33:0] travel_r, dist_u;
  logic [31:0] tick_cnt_r;
  logic tick, sens_edge, wr_go, wr_ok, vel_ok, dist_ok;

  ////////////////////////////////////////////////////////////////////////
  // sensor pin conditioning
  sov_sync3 u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(sensor_in),
    .q(sens_q)
  );
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sens_d_r <= 1'b0;
    end else begin
      sens_d_r <= sens_q;
    end
  end
  assign sens_edge = sens_q & ~sens_d_r;

  ////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order
  assign wr_go = aw_got_r && w_got_r && !s_axi_bvalid;
  assign vel_ok = (wdata_r[31:24] == 8'h00) &&
                  (wdata_r[23:0] >= `SOV_OFS_VEL_MIN) &&
                  (wdata_r[23:0] <= vel_lim_r);
  assign dist_ok = (wdata_r[31:24] == 8'h00) &&
                   (wdata_r[23:0] <= pos_lim_r);
  always_comb begin
    wr_ok = 1'b1;
    unique case (awaddr_r)
      `SOV_ADDR_CTRL, `SOV_ADDR_RUN_VEL, `SOV_ADDR_ACT_SEL,
      `SOV_ADDR_VEL_LIM, `SOV_ADDR_POS_LIM, `SOV_ADDR_DECEL: wr_ok = 1'b1;
      `SOV_ADDR_OFS_VEL: wr_ok = vel_ok;
      `SOV_ADDR_OFS_DIST: wr_ok = dist_ok;
      default: wr_ok = 1'b0;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SOV_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r <= s_axi_awaddr;
        aw_got_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r <= s_axi_wdata;
        w_got_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `SOV_RESP_OKAY : `SOV_RESP_SLVERR;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // parameter registers; reset models power up from the saved store
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ofs_vel_r <= nv_saved_r ? nv_vel_r : `SOV_OFS_VEL_DEF;
      ofs_dist_r <= nv_saved_r ? nv_dist_r : `SOV_OFS_DIST_DEF;
      act_r <= nv_saved_r ? nv_act_r : `SOV_ACT_DEF;
      run_vel_r <= `SOV_RUN_VEL_DEF;
      vel_lim_r <= `SOV_VEL_LIM_DEF;
      pos_lim_r <= `SOV_POS_LIM_DEF;
      decel_r <= `SOV_DECEL_DEF;
    end else if (wr_go && wr_ok && s_axi_wstrb != 4'h0) begin
      unique case (awaddr_r)
        `SOV_ADDR_OFS_VEL: ofs_vel_r <= wdata_r[23:0];
        `SOV_ADDR_OFS_DIST: ofs_dist_r <= wdata_r[23:0];
        `SOV_ADDR_ACT_SEL: act_r <= wdata_r[1:0];
        `SOV_ADDR_RUN_VEL: run_vel_r <= wdata_r[23:0];
        `SOV_ADDR_VEL_LIM: vel_lim_r <= wdata_r[23:0];
        `SOV_ADDR_POS_LIM: pos_lim_r <= wdata_r[23:0];
        `SOV_ADDR_DECEL: decel_r <= wdata_r[23:0];
        default: ;
      endcase
    end
  end
  // one-cycle command pulses from the control word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_pos_r <= 1'b0;
      start_neg_r <= 1'b0;
      stop_r <= 1'b0;
      save_r <= 1'b0;
    end else begin
      start_pos_r <= wr_go && awaddr_r == `SOV_ADDR_CTRL &&
                     wdata_r[`SOV_CTRL_START_POS];
      start_neg_r <= wr_go && awaddr_r == `SOV_ADDR_CTRL &&
                     wdata_r[`SOV_CTRL_START_NEG];
      stop_r <= wr_go && awaddr_r == `SOV_ADDR_CTRL &&
                wdata_r[`SOV_CTRL_STOP];
      save_r <= wr_go && awaddr_r == `SOV_ADDR_CTRL &&
                wdata_r[`SOV_CTRL_SAVE];
    end
  end
  // saved store: survives aresetn, erased only by nv_init_n
  always_ff @(posedge aclk) begin
    if (!nv_init_n) begin
      nv_saved_r <= 1'b0;
      nv_vel_r <= `SOV_OFS_VEL_DEF;
      nv_dist_r <= `SOV_OFS_DIST_DEF;
      nv_act_r <= `SOV_ACT_DEF;
    end else if (save_r) begin
      nv_saved_r <= 1'b1;
      nv_vel_r <= ofs_vel_r;
      nv_dist_r <= ofs_dist_r;
      nv_act_r <= act_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read channel
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (s_axi_araddr)
      `SOV_ADDR_RUN_VEL: rd_val = {8'h00, run_vel_r};
      `SOV_ADDR_OFS_VEL: rd_val = {8'h00, ofs_vel_r};
      `SOV_ADDR_OFS_DIST: rd_val = {8'h00, ofs_dist_r};
      `SOV_ADDR_ACT_SEL: rd_val = {30'h0000_0000, act_r};
      `SOV_ADDR_VEL_LIM: rd_val = {8'h00, vel_lim_r};
      `SOV_ADDR_POS_LIM: rd_val = {8'h00, pos_lim_r};
      `SOV_ADDR_DECEL: rd_val = {8'h00, decel_r};
      `SOV_ADDR_STATUS: rd_val = {24'h00_0000, nv_saved_r, sensed_r,
                                  dir_r, 1'b0, st_r};
      `SOV_ADDR_POSITION: rd_val = pos_r;
      `SOV_ADDR_LATCH: rd_val = latch_r;
      default: rd_val = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SOV_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= (s_axi_araddr > `SOV_ADDR_LATCH ||
                      s_axi_araddr == `SOV_ADDR_CTRL ||
                      s_axi_araddr[1:0] != 2'h0) ?
                     `SOV_RESP_SLVERR : `SOV_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // motion tick, one per millisecond
  assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn || tick) begin
      tick_cnt_r <= 32'h0000_0000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
    end
  end
  assign dist_u = 34'(ofs_dist_r) * `SOV_MILLI_TO_MICRO;

  // move sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= sov_pkg::SOV_IDLE;
      speed_r <= 24'h00_0000;
      dir_r <= 1'b0;
      moving_r <= 1'b0;
      sensed_r <= 1'b0;
      latch_r <= 32'h0000_0000;
      travel_r <= 34'h0_0000_0000;
    end else begin
      unique case (st_r)
        sov_pkg::SOV_IDLE: begin
          if (start_pos_r || start_neg_r) begin
            st_r <= sov_pkg::SOV_RUN;
            dir_r <= start_neg_r;
            speed_r <= run_vel_r;
            moving_r <= 1'b1;
            sensed_r <= 1'b0;
          end
        end
        sov_pkg::SOV_RUN: begin
          if (sens_edge && !sensed_r) begin
            sensed_r <= 1'b1;
            if (act_r == `SOV_ACT_HARD) begin
              st_r <= sov_pkg::SOV_IDLE;
              speed_r <= 24'h00_0000;
              moving_r <= 1'b0;
            end else if (act_r == `SOV_ACT_SOFT) begin
              st_r <= sov_pkg::SOV_SOFT;
            end else begin
              st_r <= sov_pkg::SOV_OFFS;
              speed_r <= ofs_vel_r;
              latch_r <= pos_nxt;
              travel_r <= 34'h0_0000_0000;
            end
          end else if (stop_r) begin
            st_r <= sov_pkg::SOV_SOFT;
          end
        end
        sov_pkg::SOV_OFFS: begin
          speed_r <= ofs_vel_r;
          if (stop_r) begin
            st_r <= sov_pkg::SOV_SOFT;
          end else if (tick) begin
            if (travel_r + 34'(speed_r) >= dist_u) begin
              st_r <= sov_pkg::SOV_IDLE;
              speed_r <= 24'h00_0000;
              moving_r <= 1'b0;
            end else begin
              travel_r <= travel_r + 34'(speed_r);
            end
          end
        end
        sov_pkg::SOV_SOFT: begin
          if (tick) begin
            if (speed_r <= decel_r) begin
              st_r <= sov_pkg::SOV_IDLE;
              speed_r <= 24'h00_0000;
              moving_r <= 1'b0;
            end else begin
              speed_r <= speed_r - decel_r;
            end
          end
        end
        default: st_r <= sov_pkg::SOV_IDLE;
      endcase
    end
  end
  // position in micro user units, both directions; latch sees same value
  always_comb begin
    pos_nxt = pos_r;
    if (tick && moving_r) begin
      pos_nxt = dir_r ? pos_r - 32'(speed_r) : pos_r + 32'(speed_r);
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_r <= 32'h0000_0000;
    end else begin
      pos_r <= pos_nxt;
    end
  end
  assign motor_cmd = {moving_r, dir_r, speed_r};

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ofs_vel_floor_a: assert property (ofs_vel_r >= `SOV_OFS_VEL_MIN)
    else $error("offset velocity below floor");
  ofs_vel_live_a: assert property (
    st_r == sov_pkg::SOV_OFFS && $past(st_r) == sov_pkg::SOV_OFFS
    |-> speed_r == $past(ofs_vel_r))
    else $error("offset velocity not applied at once");
  restore_saved_a: assert property (
    $rose(aresetn) && nv_saved_r |-> ofs_vel_r == nv_vel_r)
    else $error("saved offset velocity not restored");
  factory_def_a: assert property (
    $rose(aresetn) && !nv_saved_r |-> ofs_vel_r == `SOV_OFS_VEL_DEF)
    else $error("factory offset velocity not loaded");
  offset_switch_a: assert property (
    st_r == sov_pkg::SOV_RUN && sens_edge && act_r == `SOV_ACT_OFFSET
    |=> st_r == sov_pkg::SOV_OFFS && speed_r == $past(ofs_vel_r))
    else $error("no switch to offset velocity");
  offset_dist_a: assert property (
    st_r == sov_pkg::SOV_OFFS |-> travel_r <= dist_u)
    else $error("travel beyond offset distance");
  neg_dir_a: assert property (
    st_r == sov_pkg::SOV_IDLE && start_neg_r |=> dir_r && moving_r)
    else $error("negative move not started");
  hard_stop_a: assert property (
    st_r == sov_pkg::SOV_RUN && sens_edge && act_r == `SOV_ACT_HARD
    |=> speed_r == 24'h00_0000 && !moving_r)
    else $error("hard stop not immediate");
  latch_pos_a: assert property (
    st_r == sov_pkg::SOV_RUN && sens_edge && act_r == `SOV_ACT_OFFSET
    |=> latch_r == pos_r)
    else $error("sensor position not latched");
  first_only_a: assert property (
    st_r == sov_pkg::SOV_RUN |-> !sensed_r)
    else $error("second sensor detection acted on");
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  offs_seen_c: cover property (st_r == sov_pkg::SOV_OFFS ##1
                               st_r == sov_pkg::SOV_IDLE);
  soft_seen_c: cover property (st_r == sov_pkg::SOV_SOFT);
  neg_move_c: cover property (st_r == sov_pkg::SOV_RUN && dir_r);
  save_seen_c: cover property (save_r);
endmodule : sov_offset_stop

// *** tb/sov_sensor_model.sv ***
// sensor pin model that trips only while the carriage is moving
module sov_sensor_model #(
  parameter int PULSE = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire sov_pkg::sov_motor_t motor_cmd,
  input wire logic trip,
  output logic sensor_in
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned hold_r;
  ////////////////////////////////////////////////////////////////////////////
  // flag only passes the sensor while moving, then holds for a few cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_r <= 0;
    end else if (trip && motor_cmd.moving) begin
      hold_r <= PULSE;
    end else if (hold_r != 0) begin
      hold_r <= hold_r - 1;
    end
  end
  // active-high level, low whenever the flag is clear of the sensor
  assign sensor_in = (hold_r != 0);
endmodule : sov_sensor_model

// *** tb/sov_offset_stop_tb_top.sv ***
// self-checking bench of the offset-stop block over axi4-lite
`include "sov_defines.svh"
`define SOV_CHK(got, exp) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); \
  end \
end
module sov_offset_stop_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TICKS = 20;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic nv_init_n = 1'b0;
  logic sensor_in;
  logic trip = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  sov_pkg::sov_motor_t motor_cmd;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [31:0] pos;
  logic [31:0] lat;
  int travel;
  // free-running 100 MHz clock
  always #5 aclk = ~aclk;
  sov_offset_stop #(.TICK_CYCLES(TICKS)) dut (
    .aclk(aclk), .aresetn(aresetn), .nv_init_n(nv_init_n),
    .sensor_in(sensor_in), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .motor_cmd(motor_cmd)
  );
  sov_sensor_model #(.PULSE(8)) sensor (
    .aclk(aclk), .aresetn(aresetn), .motor_cmd(motor_cmd),
    .trip(trip), .sensor_in(sensor_in)
  );
  ////////////////////////////////////////////////////////////////////////////
  // bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `SOV_CHK(s_axi_bresp, er)
  endtask : wr
  task automatic rdreg(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask : rdreg
  task automatic chkreg(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rdreg(a, d);
    `SOV_CHK(d, e)
    `SOV_CHK(s_axi_rresp, `SOV_RESP_OKAY)
  endtask : chkreg
  // wait for a motor command, bounded, then compare it
  task automatic wait_cmd(input logic mv, input logic [23:0] sp);
    int n;
    n = 0;
    while (!(motor_cmd.moving === mv && motor_cmd.speed === sp)
           && n < 5000) begin
      @(posedge aclk);
      n++;
    end
    `SOV_CHK({motor_cmd.moving, motor_cmd.speed}, {mv, sp})
  endtask : wait_cmd
  task automatic fire();
    @(posedge aclk);
    trip <= 1'b1;
    @(posedge aclk);
    trip <= 1'b0;
  endtask : fire
  task automatic reset(input logic erase);
    aresetn <= 1'b0;
    nv_init_n <= ~erase;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    nv_init_n <= 1'b1;
    @(posedge aclk);
  endtask : reset
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////
  // watchdog against a hung handshake or motion
  initial begin
    repeat (60000) @(posedge aclk);
    n_mismatch++;
    complete_run();
  end
  ////////////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    reset(1'b1);
    // factory values after an erased store
    chkreg(`SOV_ADDR_OFS_VEL, 32'h0000_03E8);
    chkreg(`SOV_ADDR_OFS_DIST, 32'h0000_0000);
    chkreg(`SOV_ADDR_ACT_SEL, 32'h0000_0002);
    chkreg(`SOV_ADDR_STATUS, 32'h0000_0001);
    // offset velocity limits at both ends
    wr(`SOV_ADDR_OFS_VEL, 32'h0000_0000, `SOV_RESP_SLVERR);
    chkreg(`SOV_ADDR_OFS_VEL, 32'h0000_03E8);
    wr(`SOV_ADDR_OFS_VEL, 32'h0000_0001, `SOV_RESP_OKAY);
    wr(`SOV_ADDR_OFS_VEL, 32'h000F_4240, `SOV_RESP_OKAY);
    wr(`SOV_ADDR_OFS_VEL, 32'h000F_4241, `SOV_RESP_SLVERR);
    chkreg(`SOV_ADDR_OFS_VEL, 32'h000F_4240);
    wr(8'h40, 32'h0000_0001, `SOV_RESP_SLVERR);
    // offset distance limit follows the position limit
    wr(`SOV_ADDR_POS_LIM, 32'h0000_0064, `SOV_RESP_OKAY);
    wr(`SOV_ADDR_OFS_DIST, 32'h0000_0065, `SOV_RESP_SLVERR);
    wr(`SOV_ADDR_OFS_DIST, 32'h0000_0064, `SOV_RESP_OKAY);
    wr(`SOV_ADDR_OFS_DIST, 32'h0000_0004, `SOV_RESP_OKAY);
    wr(`SOV_ADDR_ACT_SEL, 32'h0000_0002, `SOV_RESP_OKAY);
    // offset stop in each direction
    for (int dir = 0; dir < 2; dir++) begin
      wr(`SOV_ADDR_OFS_VEL, 32'h0000_01F4, `SOV_RESP_OKAY);
      wr(`SOV_ADDR_CTRL, dir ? 32'h2 : 32'h1, `SOV_RESP_OKAY);
      wait_cmd(1'b1, 24'h00_2710);
      fire();
      wait_cmd(1'b1, 24'h00_01F4);
      `SOV_CHK(motor_cmd.dir_neg, dir[0])
      rdreg(`SOV_ADDR_LATCH, lat);
      fire();
      repeat (16) @(posedge aclk);
      chkreg(`SOV_ADDR_LATCH, lat);
      wr(`SOV_ADDR_OFS_VEL, 32'h0000_0320, `SOV_RESP_OKAY);
      wait_cmd(1'b1, 24'h00_0320);
      wait_cmd(1'b0, 24'h00_0000);
      chkreg(`SOV_ADDR_STATUS, {24'h0, 1'b0, 1'b1, dir[0], 5'h01});
      rdreg(`SOV_ADDR_POSITION, pos);
      travel = dir ? $signed(lat) - $signed(pos) : $signed(pos) - $signed(lat);
      `SOV_CHK(travel >= 4000 && travel < 4000 + 800, 1'b1)
    end
    // hard stop and soft stop actions
    for (int act = 0; act < 2; act++) begin
      wr(`SOV_ADDR_ACT_SEL, 32'(act), `SOV_RESP_OKAY);
      wr(`SOV_ADDR_CTRL, 32'h0000_0001, `SOV_RESP_OKAY);
      wait_cmd(1'b1, 24'h00_2710);
      fire();
      repeat (12) @(posedge aclk);
      `SOV_CHK(motor_cmd.moving, act[0])
      wait_cmd(1'b0, 24'h00_0000);
    end
    // unsaved value is lost, saved value survives a power cycle
    wr(`SOV_ADDR_OFS_VEL, 32'h0000_0384, `SOV_RESP_OKAY);
    reset(1'b0);
    chkreg(`SOV_ADDR_OFS_VEL, 32'h0000_03E8);
    wr(`SOV_ADDR_OFS_VEL, 32'h0000_02BC, `SOV_RESP_OKAY);
    wr(`SOV_ADDR_CTRL, 32'h0000_0008, `SOV_RESP_OKAY);
    wr(`SOV_ADDR_OFS_VEL, 32'h0000_0384, `SOV_RESP_OKAY);
    reset(1'b0);
    chkreg(`SOV_ADDR_OFS_VEL, 32'h0000_02BC);
    chkreg(`SOV_ADDR_STATUS, 32'h0000_0081);
    reset(1'b1);
    chkreg(`SOV_ADDR_OFS_VEL, 32'h0000_03E8);
    complete_run();
  end
endmodule : sov_offset_stop_tb_top
